// [jtag_config_port.sv]
`timescale 1ns/1ns
module jtag_config_port
   import jtag_cfg_pkg::*;
(
   input  wire logic             clock,
   input  wire logic             nrst,
   input  wire logic             trst_n,
   input  wire pin_in_s          pins,
   input  wire logic             ps_loading,
   input  wire logic [IO_W-1:0]  core_io_out,
   input  wire logic [IO_W-1:0]  core_io_oe,
   input  wire logic [IO_W-1:0]  io_in,
   output logic                  tdo,
   output logic                  tdo_oe,
   output logic      [IO_W-1:0]  io_out,
   output logic      [IO_W-1:0]  io_oe,
   output cfg_out_s              cfg
);

   // ==================================================
   // Functions
   function automatic tap_state_e next_state(input tap_state_e s, input logic m);
      case (s)
         tap_reset: next_state = m ? tap_reset : tap_idle;
         tap_idle:  next_state = m ? sel_dr : tap_idle;
         sel_dr:    next_state = m ? sel_ir : cap_dr;
         cap_dr:    next_state = m ? ex1_dr : sh_dr;
         sh_dr:     next_state = m ? ex1_dr : sh_dr;
         ex1_dr:    next_state = m ? upd_dr : pau_dr;
         pau_dr:    next_state = m ? ex2_dr : pau_dr;
         ex2_dr:    next_state = m ? upd_dr : sh_dr;
         upd_dr:    next_state = m ? sel_dr : tap_idle;
         sel_ir:    next_state = m ? tap_reset : cap_ir;
         cap_ir:    next_state = m ? ex1_ir : sh_ir;
         sh_ir:     next_state = m ? ex1_ir : sh_ir;
         ex1_ir:    next_state = m ? upd_ir : pau_ir;
         pau_ir:    next_state = m ? ex2_ir : pau_ir;
         ex2_ir:    next_state = m ? upd_ir : sh_ir;
         default:   next_state = m ? sel_dr : tap_idle;
      endcase
   endfunction

   // Instructions that take the device away from any other loader
   function automatic logic takes_over(input logic [IR_W-1:0] i);
      takes_over = (i == INSTR_PROGRAM) || (i == INSTR_CFG_IO);
   endfunction

   function automatic int dr_len(input logic [IR_W-1:0] i);
      if (i == INSTR_IDCODE) begin
         dr_len = LEN_ID;
      end else if ((i == INSTR_SAMPLE) || (i == INSTR_CFG_IO)) begin
         dr_len = LEN_BSR;
      end else begin
         dr_len = LEN_ONE;
      end
   endfunction

   function automatic logic [DR_W-1:0] shift_in(input logic [DR_W-1:0] v,
                                                input int len, input logic b);
      logic [DR_W-1:0] t;
      t = v >> 1;
      t[len-1] = b;
      shift_in = t;
   endfunction

   // ==================================================
   // Test reset: async assert, clocked release
   logic             rst_any_n;
   logic [1:0]       trst_sync_r;
   logic             tap_rst_n;

   // Optional pin: tie high when absent
   assign rst_any_n = nrst & trst_n;

   always_ff @(posedge clock or negedge rst_any_n) begin
      if (!rst_any_n) begin
         trst_sync_r <= 2'h0;
      end else begin
         trst_sync_r <= {trst_sync_r[0], 1'b1};
      end
   end
   assign tap_rst_n = trst_sync_r[1];

   // ==================================================
   // Pin synchronisers and TCK edges
   pin_in_s          pin_s1_r;
   pin_in_s          pin_s2_r;
   logic             tck_prev_r;
   logic [IO_W-1:0]  io_s1_r;
   logic [IO_W-1:0]  io_s2_r;
   logic             tck_rise;
   logic             tck_fall;

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         pin_s1_r   <= '0;
         pin_s2_r   <= '0;
         tck_prev_r <= 1'b0;
         io_s1_r    <= '0;
         io_s2_r    <= '0;
      end else begin
         pin_s1_r   <= pins;
         pin_s2_r   <= pin_s1_r;
         tck_prev_r <= pin_s2_r.tck;
         io_s1_r    <= io_in;
         io_s2_r    <= io_s1_r;
      end
   end

   // TCK is far slower than clock, so a sampled edge is one pulse
   assign tck_rise = pin_s2_r.tck & ~tck_prev_r;
   assign tck_fall = ~pin_s2_r.tck & tck_prev_r;

   // ==================================================
   // Controller state
   tap_state_e       state_r;
   tap_state_e       state_nxt;

   assign state_nxt = next_state(state_r, pin_s2_r.tms);

   always_ff @(posedge clock or negedge tap_rst_n) begin
      if (!tap_rst_n) begin
         state_r <= tap_reset;
      end else if (tck_rise) begin
         state_r <= state_nxt;
      end
   end

   // ==================================================
   // Instruction register
   logic [IR_W-1:0]  ir_sh_r;
   logic [IR_W-1:0]  ir_r;

   always_ff @(posedge clock or negedge tap_rst_n) begin
      if (!tap_rst_n) begin
         ir_sh_r <= IR_CAPTURE;
         ir_r    <= INSTR_IDCODE;
      end else if (tck_rise) begin
         case (state_r)
            tap_reset: ir_r <= INSTR_IDCODE;
            cap_ir:    ir_sh_r <= IR_CAPTURE;
            sh_ir:     ir_sh_r <= {pin_s2_r.tdi, ir_sh_r[IR_W-1:1]};
            upd_ir:    ir_r <= ir_sh_r;
            default: begin
            end
         endcase
      end
   end

   // ==================================================
   // Data registers
   logic             bypass_r;
   logic [DR_W-1:0]  dr_sh_r;
   logic [BSR_W-1:0] bsr_upd_r;

   always_ff @(posedge clock or negedge tap_rst_n) begin
      if (!tap_rst_n) begin
         bypass_r  <= 1'b0;
         dr_sh_r   <= '0;
         bsr_upd_r <= '0;
      end else if (tck_rise) begin
         case (state_r)
            cap_dr: begin
               bypass_r <= 1'b0;
               if (ir_r == INSTR_IDCODE) begin
                  dr_sh_r <= ID_VALUE;
               end else begin
                  dr_sh_r <= DR_W'({io_oe, io_s2_r});
               end
            end
            sh_dr: begin
               bypass_r <= pin_s2_r.tdi;
               dr_sh_r  <= shift_in(dr_sh_r, dr_len(ir_r), pin_s2_r.tdi);
            end
            upd_dr: begin
               if (ir_r == INSTR_CFG_IO) begin
                  bsr_upd_r <= dr_sh_r[BSR_W-1:0];
               end
            end
            default: begin
            end
         endcase
      end
   end

   // ==================================================
   // TDO on the falling edge, enabled only while shifting
   always_ff @(posedge clock or negedge tap_rst_n) begin
      if (!tap_rst_n) begin
         tdo    <= 1'b0;
         tdo_oe <= 1'b0;
      end else if (tck_fall) begin
         tdo_oe <= (state_r == sh_ir) || (state_r == sh_dr);
         if (state_r == sh_ir) begin
            tdo <= ir_sh_r[0];
         end else if (dr_len(ir_r) == LEN_ONE) begin
            tdo <= bypass_r;
         end else begin
            tdo <= dr_sh_r[0];
         end
      end
   end

   // ==================================================
   // Configuration stream to the loader
   always_ff @(posedge clock or negedge tap_rst_n) begin
      if (!tap_rst_n) begin
         cfg <= '0;
      end else begin
         // Active forces the loader onto this port over any other scheme
         cfg.active <= (ir_r == INSTR_PROGRAM);
         cfg.plain  <= (ir_r == INSTR_PROGRAM);
         // Only taking-over codes stop a passive serial load
         cfg.abort  <= tck_rise && (state_r == upd_ir) && ps_loading
                       && takes_over(ir_sh_r);
         cfg.valid  <= tck_rise && (state_r == sh_dr) && (ir_r == INSTR_PROGRAM);
         if (tck_rise && (state_r == sh_dr)) begin
            cfg.data <= pin_s2_r.tdi;
         end
      end
   end

   // ==================================================
   // User I/O steering
   always_ff @(posedge clock or negedge tap_rst_n) begin
      if (!tap_rst_n) begin
         io_out <= '0;
         io_oe  <= '0;
      end else if (ir_r == INSTR_PROGRAM) begin
         io_out <= '0;
         io_oe  <= '0;
      end else if (ir_r == INSTR_CFG_IO) begin
         io_out <= bsr_upd_r[IO_W-1:0];
         io_oe  <= bsr_upd_r[BSR_W-1:IO_W];
      end else begin
         io_out <= core_io_out;
         io_oe  <= core_io_oe;
      end
   end

   // ==================================================
   // Run of TMS-high rises, only for the reset check below
   logic [2:0]       tms_run_r;

   always_ff @(posedge clock or negedge tap_rst_n) begin
      if (!tap_rst_n) begin
         tms_run_r <= '0;
      end else if (tck_rise) begin
         if (!pin_s2_r.tms) begin
            tms_run_r <= '0;
         end else if (tms_run_r != 3'(TMS_RESET_RISES)) begin
            tms_run_r <= tms_run_r + 3'h1;
         end
      end
   end

   // ==================================================
   // Checks
   tdo_hiz_a: assert property (@(posedge clock) disable iff (!tap_rst_n)
      (tck_fall && (state_r != sh_dr) && (state_r != sh_ir)) |=> !tdo_oe)
      else $error("TDO driven outside shift");

   tdo_fall_a: assert property (@(posedge clock) disable iff (!tap_rst_n)
      $changed(tdo) |-> $past(tck_fall))
      else $error("TDO moved without falling TCK");

   tms_step_a: assert property (@(posedge clock) disable iff (!tap_rst_n)
      tck_rise |=> (state_r == $past(state_nxt)))
      else $error("Controller ignored TMS at rising TCK");

   hold_still_a: assert property (@(posedge clock) disable iff (!tap_rst_n)
      !tck_rise |=> $stable(state_r))
      else $error("Controller moved without rising TCK");

   trst_reset_a: assert property (@(posedge clock) disable iff (!nrst)
      !tap_rst_n |-> (state_r == tap_reset) && !tdo_oe)
      else $error("Test reset did not clear controller");

   user_hiz_a: assert property (@(posedge clock) disable iff (!tap_rst_n)
      (ir_r == INSTR_PROGRAM) |=> (io_oe == '0))
      else $error("User I/O driven during port configuration");

   ps_abort_a: assert property (@(posedge clock) disable iff (!tap_rst_n)
      (tck_rise && (state_r == upd_ir) && ps_loading && takes_over(ir_sh_r))
      |=> cfg.abort ##1 !cfg.abort)
      else $error("Passive serial load not aborted");

   no_abort_a: assert property (@(posedge clock) disable iff (!tap_rst_n)
      (tck_rise && (state_r == upd_ir) && !takes_over(ir_sh_r)) |=> !cfg.abort)
      else $error("Harmless instruction stopped a load");

   bypass_delay_a: assert property (@(posedge clock) disable iff (!tap_rst_n)
      (tck_rise && (state_r == sh_dr) && (ir_r == INSTR_BYPASS))
      |=> (bypass_r == $past(pin_s2_r.tdi)))
      else $error("Bypass bit lost");

   cfg_bit_a: assert property (@(posedge clock) disable iff (!tap_rst_n)
      (tck_rise && (state_r == sh_dr) && (ir_r == INSTR_PROGRAM))
      |=> cfg.valid && (cfg.data == $past(pin_s2_r.tdi)) && cfg.plain)
      else $error("Configuration bit not delivered");

   tap_reset_a: assert property (@(posedge clock) disable iff (!tap_rst_n)
      (tms_run_r == 3'(TMS_RESET_RISES)) |-> (state_r == tap_reset))
      else $error("TMS-high run did not reach reset");
endmodule

// [jtag_cfg_pkg.sv]
package jtag_cfg_pkg;
   // ==================================================
   // Widths
   localparam int IR_W  = 10;
   localparam int ID_W  = 32;
   localparam int IO_W  = 8;
   localparam int BSR_W = 2 * IO_W;
   localparam int DR_W  = 32;
   localparam int LEN_ID  = ID_W;
   localparam int LEN_BSR = BSR_W;
   localparam int LEN_ONE = 1;
   localparam int TMS_RESET_RISES = 5;
   // ==================================================
   // Instruction codes and fixed values
   localparam logic [IR_W-1:0] INSTR_BYPASS  = 10'h3ff;
   localparam logic [IR_W-1:0] INSTR_IDCODE  = 10'h006;
   localparam logic [IR_W-1:0] INSTR_SAMPLE  = 10'h005;
   localparam logic [IR_W-1:0] INSTR_CFG_IO  = 10'h00d;
   localparam logic [IR_W-1:0] INSTR_PROGRAM = 10'h002;
   localparam logic [IR_W-1:0] IR_CAPTURE    = 10'h001;
   // Arbitrary identification value
   localparam logic [ID_W-1:0] ID_VALUE      = 32'h0000_1001;
   // ==================================================
   // Types
   typedef enum logic [3:0] {
      tap_reset, tap_idle,
      sel_dr, cap_dr, sh_dr, ex1_dr, pau_dr, ex2_dr, upd_dr,
      sel_ir, cap_ir, sh_ir, ex1_ir, pau_ir, ex2_ir, upd_ir
   } tap_state_e;

   typedef struct packed {
      logic tck;
      logic tms;
      logic tdi;
   } pin_in_s;

   typedef struct packed {
      logic active;
      logic plain;
      logic abort;
      logic valid;
      logic data;
   } cfg_out_s;
endpackage

// [jtag_host.sv]
`timescale 1ns/1ns
// ==================================================
// Host side of the test port; TCK idles low
module jtag_host
   import jtag_cfg_pkg::*;
(
   input  wire logic clock,
   input  wire logic tdo,
   output pin_in_s   pins,
   output logic      trst_n
);
   initial begin
      pins   = 3'h3;
      trst_n = 1'b1;
   end
   task automatic set_trst(input logic v);
      trst_n = v;
   endtask
   // TMS/TDI change with TCK low, held through the rise
   task automatic tck_cycle(input logic ms, input logic di, output logic so);
      pins.tms = ms;
      pins.tdi = di;
      repeat (8) @(posedge clock);
      #1 so = tdo;
      pins.tck = 1'b1;
      repeat (8) @(posedge clock);
      #1 pins.tck = 1'b0;
   endtask
   task automatic walk(input logic [7:0] seq, input int n);
      logic s;
      for (int i = 0; i < n; i++) tck_cycle(seq[i], 1'b1, s);
   endtask
   task automatic run_idle(input int n);
      logic s;
      for (int i = 0; i < n; i++) tck_cycle(1'b0, 1'b1, s);
   endtask
   // From idle through a full scan, back to idle
   task automatic scan(input logic ir, input int n, input logic [31:0] din,
                       output logic [31:0] dout);
      logic s;
      dout = '0;
      walk(ir ? 8'h03 : 8'h01, ir ? 4 : 3);
      for (int i = 0; i < n; i++) begin
         tck_cycle(i == n - 1, din[i], s);
         dout[i] = s;
      end
      walk(8'h01, 2);
   endtask
endmodule

// [jtag_config_port_tb_top.sv]
`timescale 1ns/1ns
module jtag_config_port_tb_top
   import jtag_cfg_pkg::*;
;
   logic clock, nrst, ps_loading, trst_n, tdo, tdo_oe;
   logic [IO_W-1:0] core_io_out, core_io_oe, io_in, io_out, io_oe;
   pin_in_s  pins;
   cfg_out_s cfg;
   int n_errors, checks_done, n_abort, n_oe;
   logic stream[$];
   logic [31:0] d;
   logic tdo_line;
   jtag_config_port i_dut (.clock(clock), .nrst(nrst), .trst_n(trst_n), .pins(pins),
      .ps_loading(ps_loading), .core_io_out(core_io_out), .core_io_oe(core_io_oe),
      .io_in(io_in), .tdo(tdo), .tdo_oe(tdo_oe), .io_out(io_out), .io_oe(io_oe),
      .cfg(cfg));
   // Released TDO shows the inverse, so a sample outside shift is caught
   assign tdo_line = (tdo_oe === 1'b1) ? tdo : ~tdo;
   jtag_host i_host (.clock(clock), .tdo(tdo_line), .pins(pins), .trst_n(trst_n));
   // ==================================================
   // Checking and closing
   task automatic chk(input logic ok, input string msg);
      checks_done++;
      if (ok !== 1'b1) begin
         n_errors++;
         $display("CHECK FAILED %0t %s", $time, msg);
      end
   endtask
   task automatic end_sim();
      $display("errors %0d checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // Falling edge: registered outputs are settled there
   always @(negedge clock) begin
      if (cfg.abort === 1'b1) n_abort++;
      if (cfg.valid === 1'b1) stream.push_back(cfg.data);
      if (tdo_oe === 1'b1) n_oe++;
   end
   always @(tdo) if (nrst === 1'b1 && pins.tck !== 1'b0) chk(1'b0, "tdo moved, tck high");
   // ==================================================
   // Scenarios
   task automatic t_idle_state();
      chk(tdo_oe === 1'b0 && cfg === 5'h00, "idle outputs");
      chk(io_oe === core_io_oe && io_out === core_io_out, "core io");
      i_host.walk(8'h1f, 6);
      n_oe = 0;
      i_host.scan(1'b0, 32, 32'h0, d);
      chk(d === ID_VALUE, "id value");
      // 32 bits at 16 clocks per TCK period
      chk(n_oe == 32 * 16, "tdo driven for whole shift");
      chk(tdo_oe === 1'b0, "tdo released");
   endtask
   task automatic t_no_abort();
      ps_loading = 1'b1;
      n_abort = 0;
      i_host.scan(1'b1, 10, {22'h0, INSTR_BYPASS}, d);
      chk(d[9:0] === IR_CAPTURE, "ir capture");
      i_host.scan(1'b0, 32, 32'hc3a5_0f96, d);
      chk(d === 32'h874a_1f2c, "bypass delay");
      i_host.scan(1'b1, 10, {22'h0, INSTR_SAMPLE}, d);
      i_host.scan(1'b0, 16, 32'h0, d);
      chk(d[15:0] === {core_io_oe, io_in}, "sample");
      chk(n_abort == 0, "no abort");
   endtask
   task automatic t_program();
      logic [31:0] word;
      word = 32'h9e37_79b9;
      n_abort = 0;
      stream.delete();
      i_host.scan(1'b1, 10, {22'h0, INSTR_PROGRAM}, d);
      chk(n_abort == 1, "ps abort");
      chk(cfg.active === 1'b1 && cfg.plain === 1'b1, "plain path");
      chk(io_oe === 8'h00, "io released");
      i_host.scan(1'b0, 32, word, d);
      chk(d[31:1] === word[30:0], "tdo echo");
      chk(stream.size() == 32, "bit count");
      for (int i = 0; i < 32; i++) begin
         chk(stream[i] === word[i], "bit order");
      end
      i_host.run_idle(1094);
      chk(cfg.active === 1'b1 && io_oe === 8'h00, "still loading");
   endtask
   task automatic t_cfg_io();
      n_abort = 0;
      i_host.scan(1'b1, 10, {22'h0, INSTR_CFG_IO}, d);
      chk(n_abort == 1 && cfg.active === 1'b0, "cfg io abort");
      i_host.scan(1'b0, 16, 32'h3cc3, d);
      chk(io_out === 8'hc3 && io_oe === 8'h3c, "io from port");
   endtask
   task automatic t_trst();
      i_host.scan(1'b1, 10, {22'h0, INSTR_BYPASS}, d);
      @(posedge clock);
      #1 i_host.set_trst(1'b0);
      #1 chk(tdo_oe === 1'b0 && cfg === 5'h00 && io_oe === 8'h00, "async reset");
      repeat (4) @(posedge clock);
      #1 i_host.set_trst(1'b1);
      repeat (6) @(posedge clock);
      // Reset leaves the controller in test-logic-reset, not idle
      #1 i_host.run_idle(1);
      i_host.scan(1'b0, 32, 32'h0, d);
      chk(d === ID_VALUE, "ir back to id");
   endtask
   // ==================================================
   // Clock, reset, sequence, watchdog
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   initial begin
      nrst        = 1'b0;
      ps_loading  = 1'b0;
      core_io_out = 8'h5a;
      core_io_oe  = 8'hc3;
      io_in       = 8'h96;
      repeat (8) @(posedge clock);
      #1 nrst = 1'b1;
      repeat (8) @(posedge clock);
      #1 t_idle_state();
      t_no_abort();
      t_program();
      t_cfg_io();
      t_trst();
      end_sim();
   end
   initial begin
      #400_000;
      n_errors++;
      end_sim();
   end
endmodule
